// ==== logic/pipc_pkg.sv ====
// Package for the peripheral interrupt enable and priority block.
// Assumes a single 250 MHz clock and an AHB-Lite register slave.
package pipc_pkg;
   // -------------------------------------------------------------
   // Register byte offsets
   // -------------------------------------------------------------
   localparam logic [7:0] ADDR_PIE_ONE = 8'h00;
   localparam logic [7:0] ADDR_PIE_TWO = 8'h04;
   localparam logic [7:0] ADDR_PRIO_ONE = 8'h08;
   localparam logic [7:0] ADDR_PRIO_TWO = 8'h0C;
   localparam logic [7:0] ADDR_RST_CTRL = 8'h10;
   localparam logic [7:0] ADDR_MAIN_CTRL = 8'h14;
   localparam logic [7:0] ADDR_CTRL_TWO = 8'h18;
   localparam logic [7:0] ADDR_CTRL_THREE = 8'h1C;
   localparam logic [7:0] ADDR_PFLAG_ONE = 8'h20;
   localparam logic [7:0] ADDR_PFLAG_TWO = 8'h24;
   localparam logic [7:0] ADDR_TIMER0 = 8'h28;
   // -------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------
   localparam logic [7:0] RST_PIE = 8'h00;
   localparam logic [7:0] RST_PRIO_ONE = 8'hFF;
   localparam logic [3:0] RST_PRIO_TWO = 4'hF;
   localparam logic [7:0] RST_RST_CTRL = 8'h1C;
   localparam logic [7:0] RST_CTRL_TWO = 8'hF5;
   localparam logic [7:0] RST_CTRL_THREE = 8'hC0;
   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int RC_PRIO_EN = 7;
   localparam int RC_LONG_WR = 6;
   localparam int RC_RESET_INSTR = 4;
   localparam int MC_GLOBAL_EN = 7;
   localparam int MC_PERIPH_GATE = 6;
   localparam int MC_T0_EN = 5;
   localparam int MC_X0_EN = 4;
   localparam int MC_RB_EN = 3;
   localparam int MC_T0_FLAG = 2;
   localparam int MC_X0_FLAG = 1;
   localparam int MC_RB_FLAG = 0;
   localparam int C2_EDGE0 = 6;
   localparam int C2_T0_PRIO = 2;
   localparam int C2_RB_PRIO = 0;
   localparam int C3_X2_PRIO = 7;
   localparam int C3_X1_PRIO = 6;
   localparam int C3_X2_EN = 4;
   localparam int C3_X1_EN = 3;
   localparam int C3_X2_FLAG = 1;
   localparam int C3_X1_FLAG = 0;
   localparam int T0_SIXTEEN = 8;
endpackage : pipc_pkg

// ==== logic/pipc_edge_sync.sv ====
// Two-flop synchroniser with a selectable edge detector.
// Assumes the input is asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module pipc_edge_sync (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic pin_i,
   input wire logic rising_i,
   output logic level_o,
   output logic edge_o
);
   logic meta;
   logic sync;
   logic prev;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= pin_i;
         sync <= meta;
         prev <= sync;
      end
   end

   assign level_o = sync;
   assign edge_o = rising_i ? (sync & ~prev) : (~sync & prev);
endmodule // pipc_edge_sync
`default_nettype wire

// ==== logic/pipc_ctrl.sv ====
// Interrupt enable, priority and flag logic with context shadowing.
// Assumes an AHB-Lite master, asynchronous pins and core entry strobe.
`timescale 1ns/1ps
`default_nettype none
module pipc_ctrl
   import pipc_pkg::*;
#(
   parameter int NUM_EXT = 3
) (
   input wire logic MCLK_I,
   input wire logic RESET_N_I,
   input wire logic HSEL_I,
   input wire logic [7:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   input wire logic [NUM_EXT-1:0] EXT_PIN_I,
   input wire logic [3:0] PORTB_HI_I,
   input wire logic [7:0] PERIPH_EVT_ONE_I,
   input wire logic [3:0] PERIPH_EVT_TWO_I,
   input wire logic TIMER0_TICK_I,
   input wire logic CORE_ENTRY_I,
   input wire logic [7:0] WORKING_REGISTER_I,
   input wire logic [7:0] STATUS_I,
   input wire logic [7:0] BANK_SELECT_REGISTER_I,
   input wire logic [3:0] RESET_CAUSE_SET_I,
   output logic IRQ_HIGH_O,
   output logic IRQ_LOW_O,
   output logic WAKE_O,
   output logic [7:0] SHADOW_WORKING_O,
   output logic [7:0] SHADOW_STATUS_O,
   output logic [7:0] SHADOW_BANK_O,
   output logic LONG_WRITE_O
);
   import pipc_pkg::*;

   // ----------------------------------------------------------------
   // Bus slave: zero wait state, always OKAY
   // ----------------------------------------------------------------
   logic wr_pend;
   logic [7:0] wr_addr;
   logic [7:0] rd_data;
   logic wr;

   always_ff @(posedge MCLK_I) begin
      if (!RESET_N_I) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_pend <= HSEL_I & HREADY_I & HTRANS_I[1] & HWRITE_I;
         wr_addr <= HADDR_I;
      end
   end
   assign wr = wr_pend;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0] pie_one;
   logic [3:0] pie_two;
   logic [7:0] prio_one;
   logic [3:0] prio_two;
   logic prio_en;
   logic long_wr;
   logic rst_instr;
   logic [3:0] rst_status;
   logic [7:0] main_ctrl_w;
   logic [7:0] ctrl_two;
   logic [7:0] ctrl_three_w;
   logic [7:0] pflag_one;
   logic [3:0] pflag_two;
   logic [15:0] timer0;
   logic timer0_wide;
   logic [NUM_EXT-1:0] ext_flag;
   logic t0_flag;
   logic rb_flag;
   logic [31:0] wdata;
   assign wdata = HWDATA_I;

   always_ff @(posedge MCLK_I) begin
      if (!RESET_N_I) begin
         pie_one <= RST_PIE;
         pie_two <= RST_PIE[3:0];
         prio_one <= RST_PRIO_ONE;
         prio_two <= RST_PRIO_TWO;
      end else if (wr) begin
         if (wr_addr == ADDR_PIE_ONE) pie_one <= wdata[7:0];
         if (wr_addr == ADDR_PIE_TWO) pie_two <= wdata[3:0];
         if (wr_addr == ADDR_PRIO_ONE) prio_one <= wdata[7:0];
         if (wr_addr == ADDR_PRIO_TWO) prio_two <= wdata[3:0];
      end
   end

   // Reset control: status bits are writable except watchdog and power-down
   always_ff @(posedge MCLK_I) begin
      if (!RESET_N_I) begin
         prio_en <= RST_RST_CTRL[RC_PRIO_EN];
         long_wr <= RST_RST_CTRL[RC_LONG_WR];
         rst_instr <= RST_RST_CTRL[RC_RESET_INSTR];
         rst_status <= RST_RST_CTRL[3:0];
      end else begin
         if (wr && wr_addr == ADDR_RST_CTRL) begin
            prio_en <= wdata[RC_PRIO_EN];
            long_wr <= wdata[RC_LONG_WR];
            rst_instr <= wdata[RC_RESET_INSTR];
         end
         // Hardware causes win over software writes
         rst_status <= (wr && wr_addr == ADDR_RST_CTRL) ?
            ({rst_status[3:2], wdata[1:0]} | RESET_CAUSE_SET_I) :
            (rst_status | RESET_CAUSE_SET_I);
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RESET_N_I) begin
         main_ctrl_w <= 8'h00;
         ctrl_two <= RST_CTRL_TWO;
         ctrl_three_w <= RST_CTRL_THREE;
      end else if (wr) begin
         if (wr_addr == ADDR_MAIN_CTRL) main_ctrl_w <= wdata[7:0] & 8'hF8;
         if (wr_addr == ADDR_CTRL_TWO) ctrl_two <= wdata[7:0] & 8'hF5;
         if (wr_addr == ADDR_CTRL_THREE) ctrl_three_w <= wdata[7:0] & 8'hD8;
      end
   end

   // ----------------------------------------------------------------
   // Event sources
   // ----------------------------------------------------------------
   logic [NUM_EXT-1:0] ext_edge;
   logic [NUM_EXT-1:0] edge_sel;

   genvar g;
   generate
      for (g = 0; g < NUM_EXT; g++) begin : g_ext
         // Select bits run downward: pin zero sits at the top bit
         assign edge_sel[g] = ctrl_two[C2_EDGE0 - g];
         pipc_edge_sync u_sync (
            .clk_i(MCLK_I),
            .rst_n_i(RESET_N_I),
            .pin_i(EXT_PIN_I[g]),
            .rising_i(edge_sel[g]),
            .level_o(),
            .edge_o(ext_edge[g])
         );
      end
   endgenerate

   logic [3:0] rb_meta;
   logic [3:0] rb_sync;
   logic [3:0] rb_prev;
   always_ff @(posedge MCLK_I) begin
      if (!RESET_N_I) begin
         rb_meta <= 4'h0;
         rb_sync <= 4'h0;
         rb_prev <= 4'h0;
      end else begin
         rb_meta <= PORTB_HI_I;
         rb_sync <= rb_meta;
         rb_prev <= rb_sync;
      end
   end
   logic rb_change;
   assign rb_change = |(rb_sync ^ rb_prev);

   // Timer0 counts on a same-domain tick; width chosen by a mode bit
   logic t0_wrap;
   assign t0_wrap = TIMER0_TICK_I &
      (timer0_wide ? (timer0 == 16'hFFFF) : (timer0[7:0] == 8'hFF));
   always_ff @(posedge MCLK_I) begin
      if (!RESET_N_I) begin
         timer0 <= 16'h0000;
         timer0_wide <= 1'b0;
      end else if (wr && wr_addr == ADDR_TIMER0) begin
         timer0 <= wdata[15:0];
         timer0_wide <= wdata[16];
      end else if (TIMER0_TICK_I) begin
         timer0 <= timer0_wide ? timer0 + 16'h0001 : {8'h00, timer0[7:0] + 8'h01};
      end
   end

   // ----------------------------------------------------------------
   // Flags: set wins over a software clear in the same cycle
   // ----------------------------------------------------------------
   logic [NUM_EXT-1:0] ext_wr;
   always_comb begin
      ext_wr = ext_flag;
      if (wr && wr_addr == ADDR_MAIN_CTRL) ext_wr[0] = wdata[MC_X0_FLAG];
      if (wr && wr_addr == ADDR_CTRL_THREE) begin
         ext_wr[1] = wdata[C3_X1_FLAG];
         ext_wr[2] = wdata[C3_X2_FLAG];
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RESET_N_I) begin
         ext_flag <= '0;
         t0_flag <= 1'b0;
         rb_flag <= 1'b0;
      end else begin
         ext_flag <= ext_wr | ext_edge;
         t0_flag <= ((wr && wr_addr == ADDR_MAIN_CTRL) ? wdata[MC_T0_FLAG] : t0_flag)
            | t0_wrap;
         rb_flag <= ((wr && wr_addr == ADDR_MAIN_CTRL) ? wdata[MC_RB_FLAG] : rb_flag)
            | rb_change;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RESET_N_I) begin
         pflag_one <= 8'h00;
         pflag_two <= 4'h0;
      end else begin
         pflag_one <= ((wr && wr_addr == ADDR_PFLAG_ONE) ? wdata[7:0] : pflag_one)
            | PERIPH_EVT_ONE_I;
         pflag_two <= ((wr && wr_addr == ADDR_PFLAG_TWO) ? wdata[3:0] : pflag_two)
            | PERIPH_EVT_TWO_I;
      end
   end

   // ----------------------------------------------------------------
   // Routing
   // ----------------------------------------------------------------
   logic [NUM_EXT-1:0] ext_en;
   logic [NUM_EXT-1:0] ext_prio;
   logic [11:0] per_act;
   logic [11:0] per_prio;
   logic [4:0] core_act;
   logic [4:0] core_prio;
   logic per_gate;
   logic next_high;
   logic next_low;
   logic next_wake;

   assign ext_en = {ctrl_three_w[C3_X2_EN], ctrl_three_w[C3_X1_EN], main_ctrl_w[MC_X0_EN]};
   assign ext_prio = {ctrl_three_w[C3_X2_PRIO], ctrl_three_w[C3_X1_PRIO], 1'b1};
   assign per_act = {pflag_two & pie_two, pflag_one & pie_one};
   assign per_prio = {prio_two, prio_one};
   assign core_act = {ext_flag & ext_en, t0_flag & main_ctrl_w[MC_T0_EN],
                      rb_flag & main_ctrl_w[MC_RB_EN]};
   assign core_prio = {ext_prio, ctrl_two[C2_T0_PRIO], ctrl_two[C2_RB_PRIO]};
   // Single-level mode needs the peripheral gate; two-level needs it only at the low output
   assign per_gate = prio_en | main_ctrl_w[MC_PERIPH_GATE];

   always_comb begin
      if (prio_en) begin
         next_high = |(per_act & per_prio) | |(core_act & core_prio);
         next_low = |(per_act & ~per_prio) | |(core_act & ~core_prio);
      end else begin
         next_high = (per_gate & |per_act) | |core_act;
         next_low = 1'b0;
      end
   end
   // Wake ignores the global enable; the core decides whether to vector
   assign next_wake = |(ext_flag & ext_en) | next_high | next_low;

   always_ff @(posedge MCLK_I) begin
      if (!RESET_N_I) begin
         IRQ_HIGH_O <= 1'b0;
         IRQ_LOW_O <= 1'b0;
         WAKE_O <= 1'b0;
         LONG_WRITE_O <= 1'b0;
      end else begin
         IRQ_HIGH_O <= next_high & main_ctrl_w[MC_GLOBAL_EN];
         IRQ_LOW_O <= next_low & main_ctrl_w[MC_PERIPH_GATE];
         WAKE_O <= next_wake;
         LONG_WRITE_O <= long_wr;
      end
   end

   // Context shadow captured on entry
   always_ff @(posedge MCLK_I) begin
      if (!RESET_N_I) begin
         SHADOW_WORKING_O <= 8'h00;
         SHADOW_STATUS_O <= 8'h00;
         SHADOW_BANK_O <= 8'h00;
      end else if (CORE_ENTRY_I) begin
         SHADOW_WORKING_O <= WORKING_REGISTER_I;
         SHADOW_STATUS_O <= STATUS_I;
         SHADOW_BANK_O <= BANK_SELECT_REGISTER_I;
      end
   end

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   always_comb begin
      unique case (HADDR_I)
         ADDR_PIE_ONE: rd_data = pie_one;
         ADDR_PIE_TWO: rd_data = {4'h0, pie_two};
         ADDR_PRIO_ONE: rd_data = prio_one;
         ADDR_PRIO_TWO: rd_data = {4'h0, prio_two};
         ADDR_RST_CTRL: rd_data = {prio_en, long_wr, 1'b0, rst_instr, rst_status};
         ADDR_MAIN_CTRL: rd_data = main_ctrl_w | {5'h00, t0_flag, ext_flag[0], rb_flag};
         ADDR_CTRL_TWO: rd_data = ctrl_two;
         ADDR_CTRL_THREE: rd_data = ctrl_three_w | {6'h00, ext_flag[2:1]};
         ADDR_PFLAG_ONE: rd_data = pflag_one;
         ADDR_PFLAG_TWO: rd_data = {4'h0, pflag_two};
         default: rd_data = 8'h00;
      endcase
   end

   always_ff @(posedge MCLK_I) begin
      if (!RESET_N_I) begin
         HRDATA_O <= 32'h0000_0000;
         HREADYOUT_O <= 1'b1;
         HRESP_O <= 1'b0;
      end else begin
         HREADYOUT_O <= 1'b1;
         HRESP_O <= 1'b0;
         if (HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I) begin
            HRDATA_O <= (HADDR_I == ADDR_TIMER0) ?
               {15'h0000, timer0_wide, timer0} : {24'h000000, rd_data};
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_zero_high;
      @(posedge MCLK_I) disable iff (!RESET_N_I)
      (ext_flag[0] && ext_en[0] && main_ctrl_w[MC_GLOBAL_EN]) |=> IRQ_HIGH_O;
   endproperty
   a_zero_high: assert property (p_zero_high) else $error("ext zero not high");

   property p_flag_sticky;
      @(posedge MCLK_I) disable iff (!RESET_N_I)
      t0_wrap |=> t0_flag;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("t0 flag lost");

   property p_no_low_single;
      @(posedge MCLK_I) disable iff (!RESET_N_I)
      !$past(prio_en) |-> !IRQ_LOW_O;
   endproperty
   a_no_low_single: assert property (p_no_low_single) else $error("low in single");

   property p_ext_set;
      @(posedge MCLK_I) disable iff (!RESET_N_I)
      ext_edge[1] |=> ext_flag[1];
   endproperty
   a_ext_set: assert property (p_ext_set) else $error("edge flag missed");

   property p_gate;
      @(posedge MCLK_I) disable iff (!RESET_N_I)
      (!prio_en && !main_ctrl_w[MC_PERIPH_GATE] && core_act == 5'h00) |=> !IRQ_HIGH_O;
   endproperty
   a_gate: assert property (p_gate) else $error("peripheral not gated");

   property p_wake;
      @(posedge MCLK_I) disable iff (!RESET_N_I)
      (ext_flag[2] && ext_en[2]) |=> WAKE_O;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake");

   property p_shadow;
      @(posedge MCLK_I) disable iff (!RESET_N_I)
      CORE_ENTRY_I |=> SHADOW_BANK_O == $past(BANK_SELECT_REGISTER_I);
   endproperty
   a_shadow: assert property (p_shadow) else $error("shadow wrong");

   property p_rb;
      @(posedge MCLK_I) disable iff (!RESET_N_I)
      rb_change |=> rb_flag;
   endproperty
   a_rb: assert property (p_rb) else $error("rb flag missed");
endmodule // pipc_ctrl
`default_nettype wire

// ==== verif/pipc_core_model.sv ====
// Core model: answers a pending request with a one-cycle entry pulse.
// Assumes registered request levels from the controller, one clock.
`timescale 1ns/1ps
`default_nettype none
module pipc_core_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic accept_i,
   input wire logic irq_high_i,
   input wire logic irq_low_i,
   output logic entry_o,
   output logic [7:0] working_o,
   output logic [7:0] status_o,
   output logic [7:0] bank_o,
   output logic [23:0] saved_o
);
   logic [23:0] ctx;
   logic go;
   // Context moves every cycle, so an early or late capture is seen
   assign go = accept_i & (irq_high_i | irq_low_i) & ~entry_o;
   assign working_o = ctx[23:16];
   assign status_o = ctx[15:8];
   assign bank_o = ctx[7:0];
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         entry_o <= 1'b0;
         ctx <= 24'h5A3C96;
         saved_o <= 24'h000000;
      end else begin
         entry_o <= go;
         ctx <= ctx + 24'h010203;
         if (go) begin
            saved_o <= ctx + 24'h010203;
         end
      end
   end
endmodule // pipc_core_model
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the interrupt enable and priority controller.
// Assumes the controller package, the core model and a 250 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pipc_pkg::*;
   typedef struct {
      logic [1:0] kind;
      logic [31:0] val;
      logic [31:0] mask;
   } pipc_note_t;
   logic clk, rst_n, hsel, hwrite, hready, hresp, obs, tick, accept, entry;
   logic irq_h, irq_l, wake, long_wr;
   logic [1:0] htrans;
   logic [2:0] hsize, ext_pin;
   logic [3:0] portb, evt2, cause;
   logic [7:0] haddr, evt1, working_register, stat, bank, sh_w, sh_s, sh_b;
   logic [23:0] saved;
   logic [31:0] hwdata, hrdata, seed, got, r;
   pipc_note_t q[$];
   pipc_note_t note;
   int bad_count, tests_run;

   pipc_ctrl i_pipc_ctrl (.MCLK_I(clk), .RESET_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
      .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
      .EXT_PIN_I(ext_pin), .PORTB_HI_I(portb), .PERIPH_EVT_ONE_I(evt1),
      .PERIPH_EVT_TWO_I(evt2), .TIMER0_TICK_I(tick), .CORE_ENTRY_I(entry),
      .WORKING_REGISTER_I(working_register), .STATUS_I(stat), .BANK_SELECT_REGISTER_I(bank),
      .RESET_CAUSE_SET_I(cause), .IRQ_HIGH_O(irq_h), .IRQ_LOW_O(irq_l), .WAKE_O(wake),
      .SHADOW_WORKING_O(sh_w), .SHADOW_STATUS_O(sh_s), .SHADOW_BANK_O(sh_b),
      .LONG_WRITE_O(long_wr));
   pipc_core_model i_pipc_core_model (.clk_i(clk), .rst_n_i(rst_n), .accept_i(accept),
      .irq_high_i(irq_h), .irq_low_i(irq_l), .entry_o(entry), .working_o(working_register),
      .status_o(stat), .bank_o(bank), .saved_o(saved));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic summarize();
      $display("Counts: %0d checks, %0d mismatches", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // -------------------------------------------------------------
   // Bus master and notes
   // -------------------------------------------------------------
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 40);
      if (hready !== 1'b1) begin
         bad_count++;
         $display("CHECK FAILED at %0t: bus wait timed out", $time);
         summarize();
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= w ? d : 32'h0;
      if (!w) begin
         q.push_back('{2'd0, d, m});
         obs <= 1'b1;
      end
      wait_rdy();
      if (!w) obs <= 1'b0;
   endtask

   task automatic wt(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 32'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      bus(1'b0, a, e, m);
   endtask

   // Kind 1: {long write, wake, low, high}; kind 2: shadow registers
   task automatic look(input logic [1:0] k, input logic [31:0] v, input logic [31:0] m);
      @(posedge clk);
      q.push_back('{k, v, m});
      obs <= 1'b1;
      @(posedge clk);
      obs <= 1'b0;
   endtask

   task automatic fire(input logic [7:0] e1, input logic [3:0] e2, input logic t);
      evt1 <= e1;
      evt2 <= e2;
      tick <= t;
      @(posedge clk);
      evt1 <= 8'h00;
      evt2 <= 4'h0;
      tick <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic endt(input string s);
      $display("Test %s done, %0d checks so far", s, tests_run);
   endtask

   always @(posedge clk) begin
      if (obs === 1'b1 && q.size() > 0) begin
         note = q.pop_front();
         case (note.kind)
            2'd0: got = hrdata;
            2'd1: got = {28'h0, long_wr, wake, irq_l, irq_h};
            default: got = {8'h00, sh_w, sh_s, sh_b};
         endcase
         tests_run++;
         if (note.kind == 2'd0 && hresp !== 1'b0) begin
            bad_count++;
            $display("CHECK FAILED at %0t: error response on read", $time);
         end
         if ((got & note.mask) !== (note.val & note.mask)) begin
            bad_count++;
            $display("CHECK FAILED at %0t: kind %0d got %h want %h", $time, note.kind, got,
                     note.val);
         end
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      summarize();
   end

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   initial begin
      {rst_n, hsel, hwrite, obs, tick, accept, htrans, ext_pin} = '0;
      {portb, evt2, cause, haddr, evt1, hwdata} = '0;
      hsize = 3'b010;
      seed = 32'd11770;
      bad_count = 0;
      tests_run = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(ADDR_PIE_ONE, 32'h0, 32'hFFFFFFFF);
      rd(ADDR_PIE_TWO, 32'h0, 32'hFFFFFFFF);
      rd(ADDR_PRIO_ONE, 32'hFF, 32'hFFFFFFFF);
      rd(ADDR_PRIO_TWO, 32'h0F, 32'hFFFFFFFF);
      rd(ADDR_RST_CTRL, 32'h1C, 32'hFFFFFFFF);
      rd(8'h30, 32'h0, 32'hFFFFFFFF);
      endt("reset");
      for (int i = 0; i < 3; i++) begin
         r = rnd();
         wt(ADDR_PIE_ONE, r);
         wt(ADDR_PIE_TWO, r);
         wt(ADDR_PRIO_ONE, ~r);
         wt(ADDR_PRIO_TWO, ~r);
         rd(ADDR_PIE_ONE, {24'h0, r[7:0]}, 32'hFF);
         rd(ADDR_PIE_TWO, {28'h0, r[3:0]}, 32'hFF);
         rd(ADDR_PRIO_ONE, {24'h0, ~r[7:0]}, 32'hFF);
         rd(ADDR_PRIO_TWO, {28'h0, ~r[3:0]}, 32'hFF);
      end
      wt(ADDR_RST_CTRL, 32'hFF);
      rd(ADDR_RST_CTRL, 32'hDF, 32'hFF);
      look(2'd1, 32'h8, 32'h8);
      wt(ADDR_RST_CTRL, 32'h00);
      rd(ADDR_RST_CTRL, 32'h0C, 32'hFF);
      look(2'd1, 32'h0, 32'h8);
      cause <= 4'h3;
      @(posedge clk);
      cause <= 4'h0;
      rd(ADDR_RST_CTRL, 32'h0F, 32'hFF);
      endt("access");
      wt(ADDR_PRIO_ONE, 32'h0);
      wt(ADDR_PIE_ONE, 32'hFF);
      wt(ADDR_PIE_TWO, 32'h0);
      wt(ADDR_MAIN_CTRL, 32'h80);
      fire(8'h20, 4'h4, 1'b0);
      rd(ADDR_PFLAG_ONE, 32'h20, 32'hFF);
      rd(ADDR_PFLAG_TWO, 32'h04, 32'hFF);
      look(2'd1, 32'h0, 32'h3);
      wt(ADDR_MAIN_CTRL, 32'hC0);
      look(2'd1, 32'h1, 32'h3);
      wt(ADDR_PFLAG_ONE, 32'h0);
      wt(ADDR_PFLAG_TWO, 32'h0);
      look(2'd1, 32'h0, 32'h3);
      endt("single level");
      wt(ADDR_RST_CTRL, 32'h80);
      for (int k = 0; k < 8; k++) begin
         r = rnd();
         wt(ADDR_PRIO_ONE, r);
         fire(8'h01 << k, 4'h0, 1'b0);
         look(2'd1, r[k] ? 32'h1 : 32'h2, 32'h3);
         wt(ADDR_PFLAG_ONE, 32'h0);
      end
      wt(ADDR_PIE_ONE, 32'h7F);
      fire(8'h80, 4'h0, 1'b0);
      look(2'd1, 32'h0, 32'h3);
      wt(ADDR_PFLAG_ONE, 32'h0);
      wt(ADDR_PIE_TWO, 32'h2);
      wt(ADDR_PRIO_TWO, 32'h0);
      fire(8'h00, 4'h2, 1'b0);
      look(2'd1, 32'h2, 32'h3);
      wt(ADDR_PRIO_TWO, 32'hF);
      look(2'd1, 32'h1, 32'h3);
      wt(ADDR_PFLAG_TWO, 32'h0);
      endt("priority");
      wt(ADDR_MAIN_CTRL, 32'hD0);
      ext_pin <= 3'b001;
      repeat (5) @(posedge clk);
      rd(ADDR_MAIN_CTRL, 32'h2, 32'h2);
      look(2'd1, 32'h5, 32'h7);
      wt(ADDR_MAIN_CTRL, 32'hD0);
      wt(ADDR_CTRL_TWO, 32'hB5);
      ext_pin <= 3'b000;
      repeat (5) @(posedge clk);
      rd(ADDR_MAIN_CTRL, 32'h2, 32'h2);
      wt(ADDR_MAIN_CTRL, 32'hC0);
      wt(ADDR_CTRL_THREE, 32'h08);
      ext_pin <= 3'b010;
      repeat (5) @(posedge clk);
      look(2'd1, 32'h2, 32'h3);
      wt(ADDR_CTRL_THREE, 32'h90);
      ext_pin <= 3'b110;
      repeat (5) @(posedge clk);
      look(2'd1, 32'h1, 32'h3);
      wt(ADDR_CTRL_THREE, 32'h00);
      endt("external");
      wt(ADDR_CTRL_TWO, 32'hF1);
      wt(ADDR_MAIN_CTRL, 32'hE0);
      wt(ADDR_TIMER0, 32'hFF);
      fire(8'h00, 4'h0, 1'b1);
      rd(ADDR_MAIN_CTRL, 32'h4, 32'h4);
      look(2'd1, 32'h2, 32'h3);
      wt(ADDR_MAIN_CTRL, 32'hE0);
      wt(ADDR_TIMER0, 32'h100FF);
      fire(8'h00, 4'h0, 1'b1);
      rd(ADDR_MAIN_CTRL, 32'h0, 32'h4);
      rd(ADDR_TIMER0, 32'h0100, 32'hFFFF);
      wt(ADDR_TIMER0, 32'h1FFFF);
      fire(8'h00, 4'h0, 1'b1);
      rd(ADDR_MAIN_CTRL, 32'h4, 32'h4);
      wt(ADDR_CTRL_TWO, 32'hF5);
      look(2'd1, 32'h1, 32'h3);
      endt("timer0");
      wt(ADDR_CTRL_TWO, 32'hF4);
      wt(ADDR_MAIN_CTRL, 32'hC8);
      r = rnd();
      portb <= portb ^ (r[3:0] | 4'h1);
      repeat (5) @(posedge clk);
      rd(ADDR_MAIN_CTRL, 32'h1, 32'h1);
      look(2'd1, 32'h2, 32'h3);
      endt("port change");
      accept <= 1'b1;
      @(posedge clk);
      accept <= 1'b0;
      repeat (3) @(posedge clk);
      look(2'd2, {8'h00, saved}, 32'h00FFFFFF);
      endt("context");
      summarize();
   end
endmodule // testbench
`default_nettype wire
